// file: bench/xor_skip_ext_core_test.sv
// Self-checking bench of the XOR, skip and extended-op core over AHB-Lite
// Assumes a single slave whose hreadyout is the bus hready; program memory answers at once
`timescale 1ns/1ns
module xor_skip_ext_core_test;
  import xor_ext_pkg::*;
  logic clk;
  logic reset;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hready;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic [PC_W-1:0] progAddr;
  logic [15:0] progWord;
  logic [15:0] prog [0:255];
  int fails;
  int check_count;

  xor_skip_ext_core xor_skip_ext_core_i (
    .clk(clk),
    .reset(reset),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .progAddr(progAddr),
    .progWord(progWord)
  );

  assign hready = hreadyout;
  // Small memory; addresses alias every 512 bytes
  assign progWord = prog[progAddr[8:1]];

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address phase held until hready, then data phase held until hready again
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
      output logic [31:0] rdata);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, addr};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wr ? wdata : 32'h00000000;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rdata = hrdata;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    bus(1'b1, addr, data, dummy);
  endtask

  task automatic rd_check(input string what, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, addr, 32'h00000000, got);
    check(what, got, exp);
  endtask

  task automatic do_reset();
    reset <= 1'b1;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(50 * 5000);
    fails++;
    stop_test();
  end

  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    fails = 0;
    check_count = 0;
    for (int i = 0; i < 256; i++) prog[i] = 16'h0000;
    // Main program, byte address = 2 * index
    prog[8'h00] = 16'hea00;
    prog[8'h01] = 16'hea5a;
    prog[8'h02] = 16'h6705;
    prog[8'h03] = 16'h0aff;
    prog[8'h04] = 16'h0aaf;
    prog[8'h05] = 16'h1b04;
    prog[8'h06] = 16'h1904;
    prog[8'h07] = 16'h0a5a;
    prog[8'h08] = 16'he805;
    prog[8'h09] = 16'he946;
    prog[8'h0a] = 16'h0a80;
    prog[8'h0b] = 16'he8c3;
    prog[8'h20] = 16'h0014;
    // Called code: skip over a two-word op, push, both moves, indexed XOR
    prog[8'hc0] = 16'h6705;
    prog[8'hc1] = 16'hc000;
    // Second skipped word changes W if it were wrongly run
    prog[8'hc2] = 16'h0a01;
    prog[8'hc3] = 16'hea3c;
    prog[8'hc4] = 16'heb01;
    prog[8'hc5] = 16'hf107;
    prog[8'hc6] = 16'h1802;
    prog[8'hc7] = 16'heb81;
    prog[8'hc8] = 16'hf004;
    prog[8'hc9] = 16'h0a0f;
    prog[8'hca] = 16'h1804;
    do_reset();
    rd_check("ctrl", REG_CTRL, 32'h00000000);
    rd_check("pc", REG_PC, 32'h00000000);
    check("progaddr", {11'h000, progAddr}, 32'h00000000);
    check("hreadyout", {31'h0, hreadyout}, 32'h00000001);
    check("hresp", {31'h0, hresp}, 32'h00000000);
    rd_check("unmapped", 8'hfc, 32'h00000000);
    wr(REG_WORK, 32'h000000b5);
    wr(REG_BANK, 32'h00000001);
    wr(REG_PTR0, 32'h000000ff);
    wr(REG_PTR0 + PTR_STRIDE, 32'h00000003);
    wr(REG_PTR0 + 8'h08, 32'h00000105);
    wr(REG_STACK, 32'h00000040);
    wr(REG_LATCH, 32'h00000001);
    wr(REG_CTRL, 32'h00000003);
    repeat (130) @(posedge clk);
    wr(REG_CTRL, 32'h00000000);
    // Skips drop FF and 01 literals; XORs give 80, first moved 3C gives BC, 0F gives B3, second moved 3C makes 8F
    rd_check("work", REG_WORK, 32'h0000008f);
    rd_check("flags", REG_FLAGS, 32'h00000002);
    rd_check("ptr0", REG_PTR0, 32'h00000104);
    rd_check("ptr1", REG_PTR0 + PTR_STRIDE, 32'h00000ffd);
    rd_check("ptr2", REG_PTR0 + 8'h08, 32'h00000105);
    rd_check("stack", REG_STACK, 32'h00000042);
    // Extended set off: same opcodes must leave pointers alone
    do_reset();
    rd_check("ctrl2", REG_CTRL, 32'h00000000);
    wr(REG_PTR0, 32'h000000ff);
    wr(REG_PTR0 + PTR_STRIDE, 32'h00000003);
    // RAM keeps its bytes through reset: 104 holds 40, 105 holds 00
    wr(REG_WORK, 32'h000000b5);
    wr(REG_BANK, 32'h00000001);
    wr(REG_CTRL, 32'h00000002);
    repeat (60) @(posedge clk);
    wr(REG_CTRL, 32'h00000000);
    rd_check("ptr0_off", REG_PTR0, 32'h000000ff);
    rd_check("ptr1_off", REG_PTR0 + PTR_STRIDE, 32'h00000003);
    rd_check("ptr2_off", REG_PTR0 + 8'h08, 32'h00000000);
    rd_check("work_off", REG_WORK, 32'h0000009a);
    stop_test();
  end
endmodule

// file: verilog/data_ram.sv
// Data memory, one byte per address, registered read
// Assumes one request per clock from the core
`timescale 1ns/1ns
module data_ram #(
  parameter int AW = xor_ext_pkg::DATA_AW
) (
  input wire logic clk,
  input xor_ext_pkg::ram_req_s req,
  output logic [xor_ext_pkg::DATA_W-1:0] rdata
);
  import xor_ext_pkg::*;

  logic [DATA_W-1:0] mem [1 << AW];

  always_ff @(posedge clk) begin
    if (req.we) begin
      mem[req.addr[AW-1:0]] <= req.wdata;
    end
    rdata <= mem[req.addr[AW-1:0]];
  end
endmodule

// file: verilog/phase_gen.sv
// Four-phase sequencer: one phase per clock, Q1 to Q4
// Assumes enable comes from a register on the same clock
`timescale 1ns/1ns
module phase_gen (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  output logic [1:0] phase
);
  import xor_ext_pkg::*;

  // Held at Q1 while stopped so a restart begins a clean cycle
  always_ff @(posedge clk) begin
    if (reset || !enable) begin
      phase <= Q1;
    end else if (phase == Q4) begin
      phase <= Q1;
    end else begin
      phase <= phase + 2'h1;
    end
  end
endmodule

// file: verilog/xor_ext_pkg.sv
// Shared constants, types and helpers of the XOR, skip and extended-op core
// Assumes one 20 MHz clock and a 32-bit AHB-Lite register bus
package xor_ext_pkg;
  localparam int PC_W = 21;
  localparam int DATA_AW = 12;
  localparam int DATA_W = 8;
  localparam int PTR_COUNT = 3;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_WORK = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam logic [7:0] REG_BANK = 8'h0c;
  localparam logic [7:0] REG_PTR0 = 8'h10;
  localparam logic [7:0] REG_PC = 8'h1c;
  localparam logic [7:0] REG_STACK = 8'h20;
  localparam logic [7:0] REG_LATCH = 8'h24;
  localparam logic [7:0] REG_STATE = 8'h28;
  localparam logic [7:0] PTR_STRIDE = 8'h04;
  // Field positions and reset values
  localparam int CTRL_EXT = 0;
  localparam int CTRL_RUN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int FLAG_Z = 0;
  localparam int FLAG_N = 1;
  localparam int LATCH_UP_LSB = 8;
  localparam int BANK_BITS = 4;
  // Phases of one instruction cycle
  localparam logic [1:0] Q1 = 2'h0;
  localparam logic [1:0] Q2 = 2'h1;
  localparam logic [1:0] Q3 = 2'h2;
  localparam logic [1:0] Q4 = 2'h3;
  // Opcodes, pointer selects, access split and step constants
  localparam logic [7:0] OPC_XOR_LIT = 8'h0a;
  localparam logic [5:0] OPC_XOR_REG = 6'h06;
  localparam logic [6:0] OPC_TEST_SKIP = 7'h33;
  localparam logic [7:0] OPC_ADD_PTR = 8'he8;
  localparam logic [7:0] OPC_SUB_PTR = 8'he9;
  localparam logic [7:0] OPC_PUSH_LIT = 8'hea;
  localparam logic [7:0] OPC_MOVE_IDX = 8'heb;
  localparam logic [15:0] OPC_CALL_WORK = 16'h0014;
  localparam logic [3:0] OPC_MOVE_FF = 4'hc;
  localparam logic [6:0] OPC_CALL_ABS = 7'h76;
  localparam logic [7:0] OPC_LOAD_PTR = 8'hee;
  localparam logic [7:0] OPC_GOTO_ABS = 8'hef;
  localparam logic [1:0] PTR_SEL_RET = 2'h3;
  localparam logic [1:0] PTR_TWO = 2'h2;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW = 4'h0;
  localparam logic [3:0] ACCESS_HIGH = 4'hf;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [DATA_AW-1:0] PTR_DEC = 12'h001;

  typedef enum logic [1:0] {
    CY_EXEC = 2'b00,
    CY_SKIP = 2'b01,
    CY_FLUSH = 2'b10,
    CY_MOVE2 = 2'b11
  } cycle_e;

  typedef struct packed {
    logic we;
    logic [DATA_AW-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } ram_req_s;

  function automatic logic isTwoWord(input logic [15:0] w, input logic ext);
    return (w[15:12] == OPC_MOVE_FF) || (w[15:9] == OPC_CALL_ABS) ||
      (w[15:8] == OPC_LOAD_PTR) || (w[15:8] == OPC_GOTO_ABS) ||
      (ext && (w[15:8] == OPC_MOVE_IDX));
  endfunction
endpackage

// file: verilog/xor_skip_ext_core.sv
// Decode and execute of XOR ops, test-and-skip and the extended literal ops
// Assumes program words answer combinationally and a single AHB-Lite master
//
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ns
module xor_skip_ext_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [xor_ext_pkg::PC_W-1:0] progAddr,
  input wire logic [15:0] progWord
);
  import xor_ext_pkg::*;

  logic [1:0] phase;
  logic [1:0] ctrl_reg;
  logic runEn, extEn;
  logic [7:0] work_reg, bank_reg, latchHigh_reg;
  logic [4:0] latchUpper_reg;
  logic [1:0] flags_reg;
  logic [DATA_AW-1:0] ptr_reg [PTR_COUNT];
  logic [PC_W-1:0] pc_reg, stackTop_reg;
  cycle_e cycle_reg, pending_reg;
  logic skipTwo_reg, moveToIdx_reg;
  logic [15:0] ir_reg;
  logic [7:0] alu_reg;
  ram_req_s ramReq;
  logic [7:0] ramRdata;
  logic busWrPend_reg, busWe, addrPhase;
  logic [7:0] busAddr_reg;
  logic [31:0] rdMux;
  logic exec, doXorLit, doXorReg, doTst, doAddP, doSubP, doPush, doMovs, doCallw;
  logic ptrRet, q4Step;
  logic [1:0] ptrSel;
  logic [DATA_AW-1:0] lit6;

  assign runEn = ctrl_reg[CTRL_RUN];
  assign extEn = ctrl_reg[CTRL_EXT];
  assign progAddr = pc_reg;
  assign q4Step = runEn && (phase == Q4);

  phase_gen u_phase (
    .clk(clk),
    .reset(reset),
    .enable(runEn),
    .phase(phase)
  );

  data_ram #(.AW(DATA_AW)) u_ram (
    .clk(clk),
    .req(ramReq),
    .rdata(ramRdata)
  );

  function automatic logic [DATA_AW-1:0] fileAddr(input logic [7:0] f, input logic a,
      input logic ext, input logic [7:0] bank, input logic [DATA_AW-1:0] base);
    if (a) begin
      return {bank[BANK_BITS-1:0], f};
    end else if (ext && (f < ACCESS_SPLIT)) begin
      return base + {4'h0, f};
    end
    return {(f < ACCESS_SPLIT) ? ACCESS_LOW : ACCESS_HIGH, f};
  endfunction

  // Decode; extended opcodes fall through as no-ops while disabled
  always_comb begin
    exec = runEn && (cycle_reg == CY_EXEC);
    doXorLit = exec && (ir_reg[15:8] == OPC_XOR_LIT);
    doXorReg = exec && (ir_reg[15:10] == OPC_XOR_REG);
    doTst = exec && (ir_reg[15:9] == OPC_TEST_SKIP);
    doAddP = exec && extEn && (ir_reg[15:8] == OPC_ADD_PTR);
    doSubP = exec && extEn && (ir_reg[15:8] == OPC_SUB_PTR);
    doPush = exec && extEn && (ir_reg[15:8] == OPC_PUSH_LIT);
    doMovs = exec && extEn && (ir_reg[15:8] == OPC_MOVE_IDX);
    doCallw = exec && extEn && (ir_reg == OPC_CALL_WORK);
    ptrRet = (ir_reg[7:6] == PTR_SEL_RET);
    ptrSel = ptrRet ? PTR_TWO : ir_reg[7:6];
    lit6 = {6'h00, ir_reg[5:0]};
  end

  // Address stays put over Q2..Q4, so the Q2 read feeds Q3 and the test at Q4
  always_comb begin
    ramReq.addr = fileAddr(ir_reg[7:0], ir_reg[8], extEn, bank_reg, ptr_reg[2]);
    ramReq.wdata = alu_reg;
    if (cycle_reg == CY_MOVE2) begin
      ramReq.addr = moveToIdx_reg ? ptr_reg[2] + {5'h00, ir_reg[6:0]} : ir_reg[11:0];
    end else if (doMovs) begin
      ramReq.addr = ptr_reg[2] + {5'h00, ir_reg[6:0]};
    end else if (doPush) begin
      ramReq.addr = ptr_reg[2];
      ramReq.wdata = ir_reg[7:0];
    end
    ramReq.we = q4Step && ((doXorReg && ir_reg[9]) || doPush ||
      (cycle_reg == CY_MOVE2));
  end

  // Fetch at Q1: the word ahead is latched, skipped cycles still consume it
  always_ff @(posedge clk) begin
    if (reset) begin
      ir_reg <= 16'h0000;
      cycle_reg <= CY_FLUSH;
    end else if (runEn && (phase == Q1)) begin
      ir_reg <= progWord;
      cycle_reg <= pending_reg;
    end
  end

  // Process at Q3
  always_ff @(posedge clk) begin
    if (reset) begin
      alu_reg <= 8'h00;
    end else if (runEn && (phase == Q3)) begin
      if (doXorLit) begin
        alu_reg <= work_reg ^ ir_reg[7:0];
      end else if (doXorReg) begin
        alu_reg <= work_reg ^ ramRdata;
      end else if (doMovs) begin
        alu_reg <= ramRdata;
      end
    end
  end

  // Next cycle's kind, decided at Q4
  always_ff @(posedge clk) begin
    if (reset) begin
      pending_reg <= CY_EXEC;
      skipTwo_reg <= 1'b0;
      moveToIdx_reg <= 1'b0;
    end else if (q4Step) begin
      pending_reg <= CY_EXEC;
      skipTwo_reg <= 1'b0;
      if (doTst && (ramRdata == 8'h00)) begin
        pending_reg <= CY_SKIP;
        skipTwo_reg <= isTwoWord(progWord, extEn);
      end else if ((cycle_reg == CY_SKIP) && skipTwo_reg) begin
        pending_reg <= CY_SKIP;
      end else if (((doAddP || doSubP) && ptrRet) || doCallw) begin
        pending_reg <= CY_FLUSH;
      end else if (doMovs) begin
        pending_reg <= CY_MOVE2;
        moveToIdx_reg <= ir_reg[7];
      end
    end
  end

  // Program counter; a flushed cycle does not advance it
  always_ff @(posedge clk) begin
    if (reset) begin
      pc_reg <= '0;
    end else if (busWe && (busAddr_reg == REG_PC)) begin
      pc_reg <= hwdata[PC_W-1:0];
    end else if (runEn && (phase == Q1) && (pending_reg != CY_FLUSH)) begin
      pc_reg <= pc_reg + PC_STEP;
    end else if (q4Step && (doAddP || doSubP) && ptrRet) begin
      pc_reg <= stackTop_reg;
    end else if (q4Step && doCallw) begin
      pc_reg <= {latchUpper_reg, latchHigh_reg, work_reg};
    end
  end

  // Single-entry return stack; deeper stacking lives outside this block
  always_ff @(posedge clk) begin
    if (reset) begin
      stackTop_reg <= '0;
    end else if (busWe && (busAddr_reg == REG_STACK)) begin
      stackTop_reg <= hwdata[PC_W-1:0];
    end else if (q4Step && doCallw) begin
      stackTop_reg <= pc_reg;
    end
  end

  // Working register and flags; bus writes win over the core
  always_ff @(posedge clk) begin
    if (reset) begin
      work_reg <= 8'h00;
    end else if (busWe && (busAddr_reg == REG_WORK)) begin
      work_reg <= hwdata[7:0];
    end else if (q4Step && (doXorLit || (doXorReg && !ir_reg[9]))) begin
      work_reg <= alu_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      flags_reg <= 2'h0;
    end else if (busWe && (busAddr_reg == REG_FLAGS)) begin
      flags_reg <= hwdata[1:0];
    end else if (q4Step && (doXorLit || doXorReg)) begin
      flags_reg[FLAG_N] <= alu_reg[7];
      flags_reg[FLAG_Z] <= (alu_reg == 8'h00);
    end
  end

  generate
    for (genvar i = 0; i < PTR_COUNT; i++) begin : g_ptr
      localparam logic [7:0] OFS = REG_PTR0 + PTR_STRIDE * 8'(i);
      always_ff @(posedge clk) begin
        if (reset) begin
          ptr_reg[i] <= '0;
        end else if (busWe && (busAddr_reg == OFS)) begin
          ptr_reg[i] <= hwdata[DATA_AW-1:0];
        end else if (q4Step && doAddP && (ptrSel == 2'(i))) begin
          ptr_reg[i] <= ptr_reg[i] + lit6;
        end else if (q4Step && doSubP && (ptrSel == 2'(i))) begin
          ptr_reg[i] <= ptr_reg[i] - lit6;
        end else if (q4Step && doPush && (i == 2)) begin
          ptr_reg[i] <= ptr_reg[i] - PTR_DEC;
        end
      end
    end
  endgenerate

  // Software configuration; extended set starts disabled
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RESET;
      bank_reg <= 8'h00;
      latchHigh_reg <= 8'h00;
      latchUpper_reg <= 5'h00;
    end else if (busWe) begin
      if (busAddr_reg == REG_CTRL) begin
        ctrl_reg <= hwdata[1:0];
      end
      if (busAddr_reg == REG_BANK) begin
        bank_reg <= hwdata[7:0];
      end
      if (busAddr_reg == REG_LATCH) begin
        latchHigh_reg <= hwdata[7:0];
        latchUpper_reg <= hwdata[LATCH_UP_LSB+4:LATCH_UP_LSB];
      end
    end
  end

  // AHB-Lite slave, zero wait states; hsize ignored, word access only
  assign addrPhase = hsel && htrans[1] && hready;
  assign busWe = busWrPend_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    rdMux = 32'h00000000;
    case (haddr[7:0])
      REG_CTRL: rdMux[1:0] = ctrl_reg;
      REG_WORK: rdMux[7:0] = work_reg;
      REG_FLAGS: rdMux[1:0] = flags_reg;
      REG_BANK: rdMux[7:0] = bank_reg;
      REG_PTR0: rdMux[DATA_AW-1:0] = ptr_reg[0];
      REG_PTR0 + PTR_STRIDE: rdMux[DATA_AW-1:0] = ptr_reg[1];
      REG_PTR0 + PTR_STRIDE + PTR_STRIDE: rdMux[DATA_AW-1:0] = ptr_reg[2];
      REG_PC: rdMux[PC_W-1:0] = pc_reg;
      REG_STACK: rdMux[PC_W-1:0] = stackTop_reg;
      REG_LATCH: rdMux[LATCH_UP_LSB+4:0] = {latchUpper_reg, latchHigh_reg};
      REG_STATE: rdMux[6:0] = {skipTwo_reg, pending_reg, cycle_reg, phase};
      default: rdMux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      busWrPend_reg <= 1'b0;
      busAddr_reg <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      busWrPend_reg <= addrPhase && hwrite;
      if (addrPhase) begin
        busAddr_reg <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= rdMux;
      end
    end
  end

  property p_skip_one;
    @(posedge clk) disable iff (reset || !runEn)
    (q4Step && doTst && (ramRdata == 8'h00) && !isTwoWord(progWord, extEn)) |->
      ##2 (cycle_reg == CY_SKIP) ##4 (cycle_reg == CY_EXEC);
  endproperty
  a_skip_one: assert property (p_skip_one) else $error("skip not one cycle");

  property p_skip_two;
    @(posedge clk) disable iff (reset || !runEn)
    (q4Step && doTst && (ramRdata == 8'h00) && isTwoWord(progWord, extEn)) |->
      ##2 (cycle_reg == CY_SKIP) ##4 (cycle_reg == CY_SKIP) ##4 (cycle_reg == CY_EXEC);
  endproperty
  a_skip_two: assert property (p_skip_two) else $error("two-word skip wrong");

  property p_xor_lit;
    @(posedge clk) disable iff (reset)
    (q4Step && doXorLit && !busWe) |=>
      (work_reg == ($past(work_reg) ^ $past(ir_reg[7:0]))) &&
      (flags_reg[FLAG_Z] == (work_reg == 8'h00)) && (flags_reg[FLAG_N] == work_reg[7]);
  endproperty
  a_xor_lit: assert property (p_xor_lit) else $error("literal xor wrong");

  property p_xor_to_file;
    @(posedge clk) disable iff (reset)
    (q4Step && doXorReg && ir_reg[9]) |->
      ramReq.we && (ramReq.wdata == (work_reg ^ ramRdata));
  endproperty
  a_xor_to_file: assert property (p_xor_to_file) else $error("xor file write wrong");

  property p_xor_to_work;
    @(posedge clk) disable iff (reset)
    (q4Step && doXorReg && !ir_reg[9] && !busWe) |->
      !ramReq.we ##1 (work_reg == ($past(work_reg) ^ $past(ramRdata)));
  endproperty
  a_xor_to_work: assert property (p_xor_to_work) else $error("xor work write wrong");

  property p_bank_sel;
    @(posedge clk) disable iff (reset)
    (runEn && (phase == Q2) && doXorReg && ir_reg[8]) |->
      (ramReq.addr == {bank_reg[BANK_BITS-1:0], ir_reg[7:0]});
  endproperty
  a_bank_sel: assert property (p_bank_sel) else $error("bank address wrong");

  property p_indexed;
    @(posedge clk) disable iff (reset)
    (runEn && (phase == Q2) && doXorReg && !ir_reg[8] && extEn &&
      (ir_reg[7:0] < ACCESS_SPLIT)) |-> (ramReq.addr == ptr_reg[2] + {4'h0, ir_reg[7:0]});
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");

  property p_xor_phases;
    @(posedge clk) disable iff (reset)
    (runEn && (phase == Q2) && doXorReg) |-> !ramReq.we ##2 (ramReq.we == ir_reg[9]);
  endproperty
  a_xor_phases: assert property (p_xor_phases) else $error("xor phase order wrong");

  property p_ext_off;
    @(posedge clk) disable iff (reset)
    (q4Step && !extEn && !busWe) |=> $stable(ptr_reg[2]) && $stable(stackTop_reg);
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("extended op ran while off");

  property p_sub_ptr;
    @(posedge clk) disable iff (reset)
    (q4Step && doSubP && (ir_reg[7:6] == 2'h1) && !busWe) |=>
      (ptr_reg[1] == $past(ptr_reg[1]) - {6'h00, $past(ir_reg[5:0])}) && $stable(flags_reg);
  endproperty
  a_sub_ptr: assert property (p_sub_ptr) else $error("pointer subtract wrong");

  property p_add_ret;
    @(posedge clk) disable iff (reset || !runEn)
    (q4Step && doAddP && ptrRet && !busWe) |=>
      (pc_reg == $past(stackTop_reg)) &&
      (ptr_reg[2] == $past(ptr_reg[2]) + {6'h00, $past(ir_reg[5:0])})
      ##1 (cycle_reg == CY_FLUSH);
  endproperty
  a_add_ret: assert property (p_add_ret) else $error("add and return wrong");

  property p_call_work;
    @(posedge clk) disable iff (reset || !runEn)
    (q4Step && doCallw && !busWe) |=> (stackTop_reg == $past(pc_reg)) &&
      (pc_reg == {$past(latchUpper_reg), $past(latchHigh_reg), $past(work_reg)})
      ##1 (cycle_reg == CY_FLUSH);
  endproperty
  a_call_work: assert property (p_call_work) else $error("call via work wrong");

  property p_move;
    @(posedge clk) disable iff (reset || !runEn)
    (q4Step && doMovs) |-> ##2 (cycle_reg == CY_MOVE2) ##2 (ramReq.we && (phase == Q4));
  endproperty
  a_move: assert property (p_move) else $error("two-word move wrong");

  property p_push;
    @(posedge clk) disable iff (reset)
    (q4Step && doPush && !busWe) |-> ramReq.we && (ramReq.addr == ptr_reg[2]) &&
      (ramReq.wdata == ir_reg[7:0]) ##1 (ptr_reg[2] == $past(ptr_reg[2]) - PTR_DEC);
  endproperty
  a_push: assert property (p_push) else $error("push literal wrong");

  c_skip_two: cover property (@(posedge clk) q4Step && doTst && skipTwo_reg == 1'b0 &&
    (ramRdata == 8'h00) && isTwoWord(progWord, extEn));
  c_call_work: cover property (@(posedge clk) q4Step && doCallw);
  c_move: cover property (@(posedge clk) q4Step && (cycle_reg == CY_MOVE2));
endmodule
